// *** verilog/ddac_front.sv ***
// Purpose: control registers, pin mode and data capture of a dual converter
// Assumes: inputs synchronous to clk; one history step stands for one tap
// Notes: fifo depth must be a power of two
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module ddac_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // handshake terms
   assign in_ready = (count != FULL_COUNT);
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         case ({push, pop})
            2'b10: count <= count + 1'b1;
            2'b01: count <= count - 1'b1;
            default: count <= count;
         endcase
      end
   end
endmodule // ddac_fifo

////////////////////////////////////////////////////////////////////////////
module ddac_front
   import ddac_pkg::*;
#(
   parameter logic [3:0] SILICON_VERSION = 4'h1, // arbitrary value
   parameter logic [3:0] DEVICE_CODE = 4'h2, // arbitrary value
   parameter int DATA_WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // serial port pins in pin mode
   input wire logic serial_data_pin,
   input wire logic chip_select_pin,
   input wire logic serial_out_pin,
   // data port from source
   input wire logic [DATA_WIDTH-1:0] lvds_data,
   input wire logic iq_marking_clock_in,
   output logic clock_to_source,
   // converter word outputs
   output logic [DATA_WIDTH-1:0] dac_i_word,
   output logic [DATA_WIDTH-1:0] dac_q_word,
   output logic dac_word_valid,
   input wire logic dac_ready,
   // analog control words
   output logic [7:0] data_control,
   output logic [7:0] power_down,
   output logic [7:0] mix_mode,
   output logic [7:0] aux_one_low,
   output logic [7:0] aux_one_high,
   output logic [7:0] fs_two_low,
   output logic [7:0] fs_two_high,
   output logic [7:0] aux_two_low,
   output logic [7:0] aux_two_high
);
   localparam int HW = $clog2(HIST_DEPTH);

   logic [7:0] setup_hold;
   logic [7:0] sample_dly;
   logic [7:0] test_ctrl;
   logic [15:0] self_test_result_one;
   logic [15:0] self_test_result_two;
   logic [15:0] sig_one;
   logic [15:0] sig_two;
   logic seek;
   logic overflow;
   logic [DATA_WIDTH-1:0] hist_d [HIST_DEPTH];
   logic [HIST_DEPTH-1:0] hist_m;
   logic [HW-1:0] data_idx;
   logic [HW-1:0] mark_idx;
   logic [DATA_WIDTH-1:0] cap_word;
   logic [DATA_WIDTH-1:0] fmt_word;
   logic mark_sample;
   logic edge_phase;
   logic [DATA_WIDTH-1:0] i_hold;
   logic have_i;
   logic [PAIR_WIDTH-1:0] pair_data;
   logic pair_valid;
   logic fifo_in_ready;
   logic [PAIR_WIDTH-1:0] fifo_out_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic clk_div;
   logic wr_en;
   logic go_strobe;
   logic xfer_strobe;
   logic clr_strobe;
   logic [7:0] next_rdata;

   // documented field views
   logic [9:0] aux_current_word_one;
   logic [9:0] aux_current_word_two;
   logic [9:0] second_full_scale_word;
   logic aux_one_pin_select;
   logic aux_one_sink_select;
   logic aux_two_pin_select;
   logic aux_two_sink_select;
   logic self_test_go;
   logic [4:0] sampling_delay;
   logic [3:0] setup_delay;
   logic [3:0] hold_delay;

   assign aux_current_word_one = {aux_one_high[1:0], aux_one_low};
   assign aux_one_pin_select = aux_one_high[BIT_PIN_SEL];
   assign aux_one_sink_select = aux_one_high[BIT_SINK_SEL];
   assign second_full_scale_word = {fs_two_high[1:0], fs_two_low};
   assign aux_current_word_two = {aux_two_high[1:0], aux_two_low};
   assign aux_two_pin_select = aux_two_high[BIT_PIN_SEL];
   assign aux_two_sink_select = aux_two_high[BIT_SINK_SEL];
   assign self_test_go = test_ctrl[BIT_TEST_GO];
   assign sampling_delay = sample_dly[4:0];
   assign setup_delay = setup_hold[7:4];
   assign hold_delay = setup_hold[3:0];

   // write strobes; pin mode blocks register access
   assign wr_en = reg_wr && !sys_rst;
   assign go_strobe = wr_en && (reg_addr == ADDR_TEST_CTRL) && reg_wdata[BIT_TEST_GO];
   assign xfer_strobe = wr_en && (reg_addr == ADDR_TEST_CTRL) && reg_wdata[BIT_TEST_XFER];
   assign clr_strobe = wr_en && (reg_addr == ADDR_TEST_CTRL) && reg_wdata[BIT_TEST_CLR];

   ////////////////////////////////////////////////////////////////////////
   // pin mode registers: defaults plus pin-selected options
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_control <= RST_ZERO;
         data_control[BIT_FORMAT] <= serial_data_pin;
         mix_mode <= chip_select_pin ? PIN_MIX_VALUE : RST_ZERO;
         power_down <= serial_out_pin ? PIN_PD_VALUE : RST_ZERO;
      end else if (wr_en) begin
         case (reg_addr)
            ADDR_DATA_CTRL: data_control <= reg_wdata;
            ADDR_MIX_MODE: mix_mode <= reg_wdata;
            ADDR_POWER_DOWN: power_down <= reg_wdata;
            default: data_control <= data_control;
         endcase
      end
   end

   // timing, analog control and self-test control registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         setup_hold <= RST_ZERO;
         sample_dly <= RST_ZERO;
         aux_one_low <= RST_ZERO;
         aux_one_high <= RST_ZERO;
         fs_two_low <= RST_FS_TWO_LOW;
         fs_two_high <= RST_FS_TWO_HIGH;
         aux_two_low <= RST_ZERO;
         aux_two_high <= RST_ZERO;
         test_ctrl <= RST_ZERO;
      end else if (wr_en) begin
         case (reg_addr)
            ADDR_SETUP_HOLD: setup_hold <= reg_wdata;
            ADDR_SAMPLE_DLY: sample_dly <= {3'h0, reg_wdata[4:0]};
            ADDR_AUX_ONE_LOW: aux_one_low <= reg_wdata;
            ADDR_AUX_ONE_HIGH: aux_one_high <= {reg_wdata[7:6], 4'h0, reg_wdata[1:0]};
            ADDR_FS_TWO_LOW: fs_two_low <= reg_wdata;
            ADDR_FS_TWO_HIGH: fs_two_high <= {6'h00, reg_wdata[1:0]};
            ADDR_AUX_TWO_LOW: aux_two_low <= reg_wdata;
            ADDR_AUX_TWO_HIGH: aux_two_high <= {reg_wdata[7:6], 4'h0, reg_wdata[1:0]};
            ADDR_TEST_CTRL: test_ctrl <= {reg_wdata[7:5], 5'h00};
            default: setup_hold <= setup_hold;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input history line, one entry per tap
   always_ff @(posedge clk) begin
      hist_d[0] <= lvds_data;
      hist_m <= {hist_m[HIST_DEPTH-2:0], iq_marking_clock_in};
   end

   genvar k;
   generate
      for (k = 1; k < HIST_DEPTH; k++) begin : g_hist
         always_ff @(posedge clk) begin
            hist_d[k] <= hist_d[k-1];
         end
      end
   endgenerate

   // tap selection: sample delay moves data, setup earlier, hold later
   assign data_idx = HW'(HIST_BASE) + HW'(sampling_delay * SAMPLE_TAPS_PER_CODE);
   assign mark_idx = data_idx + HW'(setup_delay * SH_TAPS_PER_CODE)
      - HW'(hold_delay * SH_TAPS_PER_CODE);
   assign cap_word = hist_d[data_idx];
   assign mark_sample = hist_m[mark_idx];
   assign fmt_word = data_control[BIT_FORMAT] ? cap_word
      : {~cap_word[DATA_WIDTH-1], cap_word[DATA_WIDTH-2:0]};

   // edge phase: even steps rising, odd steps falling
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         edge_phase <= 1'b0;
      end else begin
         edge_phase <= ~edge_phase;
      end
   end

   // timing status from delayed marking sample on rising steps
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seek <= 1'b0;
      end else if (!edge_phase && !power_down[BIT_PD_INPUT]) begin
         seek <= mark_sample;
      end
   end

   // demultiplex: marking high tags the I word, the next word is Q
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         i_hold <= '0;
         have_i <= 1'b0;
         pair_data <= '0;
         pair_valid <= 1'b0;
      end else begin
         pair_valid <= 1'b0;
         if (!power_down[BIT_PD_INPUT]) begin
            if (mark_sample) begin
               i_hold <= fmt_word;
               have_i <= 1'b1;
            end else if (have_i) begin
               pair_data <= {i_hold, fmt_word};
               pair_valid <= 1'b1;
               have_i <= 1'b0;
            end
         end
      end
   end

   // sticky overflow when the buffer refuses a pair; set beats clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         overflow <= 1'b0;
      end else if (pair_valid && !fifo_in_ready) begin
         overflow <= 1'b1;
      end else if (wr_en && (reg_addr == ADDR_SEEK) && reg_wdata[BIT_OVERFLOW]) begin
         overflow <= 1'b0;
      end
   end

   ddac_fifo #(
      .WIDTH(PAIR_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_data(pair_data),
      .in_valid(pair_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   // retimed output stage toward the converters
   assign fifo_out_ready = !dac_word_valid || dac_ready;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dac_i_word <= '0;
         dac_q_word <= '0;
         dac_word_valid <= 1'b0;
      end else if (fifo_out_ready) begin
         dac_word_valid <= fifo_out_valid;
         if (fifo_out_valid) begin
            dac_i_word <= fifo_out_data[PAIR_WIDTH-1:DATA_WIDTH];
            dac_q_word <= fifo_out_data[DATA_WIDTH-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // signature step for the self-test accumulators
   function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [15:0] d);
      sig_step = {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]} ^ d;
   endfunction

   // self-test accumulators run on words leaving the buffer
   always_ff @(posedge clk) begin
      if (sys_rst || clr_strobe) begin
         sig_one <= '0;
         sig_two <= '0;
      end else if (go_strobe) begin
         sig_one <= '0;
         sig_two <= '0;
      end else if (self_test_go && fifo_out_valid && fifo_out_ready) begin
         sig_one <= sig_step(sig_one, 16'(fifo_out_data[PAIR_WIDTH-1:DATA_WIDTH]));
         sig_two <= sig_step(sig_two, 16'(fifo_out_data[DATA_WIDTH-1:0]));
      end
   end

   // readable results: clear wins over transfer
   always_ff @(posedge clk) begin
      if (sys_rst || clr_strobe) begin
         self_test_result_one <= '0;
         self_test_result_two <= '0;
      end else if (xfer_strobe) begin
         self_test_result_one <= sig_one;
         self_test_result_two <= sig_two;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock output at half rate, invertible, stopped by power-down
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_div <= 1'b0;
         clock_to_source <= 1'b0;
      end else begin
         clk_div <= ~clk_div;
         clock_to_source <= power_down[BIT_PD_CLKOUT] ? 1'b0
            : (~clk_div ^ data_control[BIT_INV_CLK]);
      end
   end

   // read mux
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ADDR_DATA_CTRL: next_rdata = data_control;
         ADDR_POWER_DOWN: next_rdata = power_down;
         ADDR_SETUP_HOLD: next_rdata = setup_hold;
         ADDR_SAMPLE_DLY: next_rdata = sample_dly;
         ADDR_SEEK: next_rdata = {overflow, 6'h00, seek};
         ADDR_MIX_MODE: next_rdata = mix_mode;
         ADDR_AUX_ONE_LOW: next_rdata = aux_one_low;
         ADDR_AUX_ONE_HIGH: next_rdata = aux_one_high;
         ADDR_FS_TWO_LOW: next_rdata = fs_two_low;
         ADDR_FS_TWO_HIGH: next_rdata = fs_two_high;
         ADDR_AUX_TWO_LOW: next_rdata = aux_two_low;
         ADDR_AUX_TWO_HIGH: next_rdata = aux_two_high;
         ADDR_TEST_CTRL: next_rdata = test_ctrl;
         ADDR_RES_ONE_LOW: next_rdata = self_test_result_one[7:0];
         ADDR_RES_ONE_HIGH: next_rdata = self_test_result_one[15:8];
         ADDR_RES_TWO_LOW: next_rdata = self_test_result_two[7:0];
         ADDR_RES_TWO_HIGH: next_rdata = self_test_result_two[15:8];
         ADDR_IDENTITY: next_rdata = {SILICON_VERSION, DEVICE_CODE};
         default: next_rdata = 8'h00;
      endcase
   end

   // registered read data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // ddac_front

// *** verilog/ddac_pkg.sv ***
// Purpose: shared constants of the dual converter front end
// Assumes: 5-bit register address space, 8-bit registers
// Notes: delay taps are modelled in units of one history step
package ddac_pkg;
   // register addresses
   localparam logic [4:0] ADDR_DATA_CTRL = 5'h02;
   localparam logic [4:0] ADDR_POWER_DOWN = 5'h03;
   localparam logic [4:0] ADDR_SETUP_HOLD = 5'h04;
   localparam logic [4:0] ADDR_SAMPLE_DLY = 5'h05;
   localparam logic [4:0] ADDR_SEEK = 5'h06;
   localparam logic [4:0] ADDR_MIX_MODE = 5'h0a;
   localparam logic [4:0] ADDR_AUX_ONE_LOW = 5'h0d;
   localparam logic [4:0] ADDR_AUX_ONE_HIGH = 5'h0e;
   localparam logic [4:0] ADDR_FS_TWO_LOW = 5'h0f;
   localparam logic [4:0] ADDR_FS_TWO_HIGH = 5'h10;
   localparam logic [4:0] ADDR_AUX_TWO_LOW = 5'h11;
   localparam logic [4:0] ADDR_AUX_TWO_HIGH = 5'h12;
   localparam logic [4:0] ADDR_TEST_CTRL = 5'h1a;
   localparam logic [4:0] ADDR_RES_ONE_LOW = 5'h1b;
   localparam logic [4:0] ADDR_RES_ONE_HIGH = 5'h1c;
   localparam logic [4:0] ADDR_RES_TWO_LOW = 5'h1d;
   localparam logic [4:0] ADDR_RES_TWO_HIGH = 5'h1e;
   localparam logic [4:0] ADDR_IDENTITY = 5'h1f;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_FS_TWO_LOW = 8'hf9;
   localparam logic [7:0] RST_FS_TWO_HIGH = 8'h01;
   // pin mode forced values
   localparam logic [7:0] PIN_MIX_VALUE = 8'h05;
   localparam logic [7:0] PIN_PD_VALUE = 8'hff;
   // field positions
   localparam int BIT_FORMAT = 7;
   localparam int BIT_INV_CLK = 4;
   localparam int BIT_PD_CLKOUT = 7;
   localparam int BIT_PD_INPUT = 6;
   localparam int BIT_PIN_SEL = 7;
   localparam int BIT_SINK_SEL = 6;
   localparam int BIT_TEST_GO = 7;
   localparam int BIT_TEST_XFER = 6;
   localparam int BIT_TEST_CLR = 5;
   localparam int BIT_OVERFLOW = 7;
   // delay step sizes and model tap
   localparam int SETUP_HOLD_STEP_PS = 80;
   localparam int SAMPLE_STEP_PS = 160;
   localparam int TAP_PS = 80;
   localparam int SAMPLE_TAPS_PER_CODE = SAMPLE_STEP_PS / TAP_PS;
   localparam int SH_TAPS_PER_CODE = SETUP_HOLD_STEP_PS / TAP_PS;
   // history line layout
   localparam int HIST_BASE = 16;
   localparam int HIST_DEPTH = 128;
   // buffering
   localparam int FIFO_DEPTH = 32;
   localparam int PAIR_WIDTH = 32;
   // clock
   localparam int CLK_PERIOD_PS = 10000;
endpackage

// *** testbench/ddac_front_sva.sv ***
// Purpose: port checks of the converter front end
// Assumes: reg_rdata follows the read edge by one cycle
// Notes: pin mode checks run only while reset is high
`timescale 1ns/100ps
module ddac_front_sva
   import ddac_pkg::*;
#(
   parameter logic [3:0] SILICON_VERSION = 4'h1,
   parameter logic [3:0] DEVICE_CODE = 4'h2,
   parameter int DATA_WIDTH = 16
) (
   // clock, reset, register port
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pin mode pins
   input wire logic serial_data_pin,
   input wire logic chip_select_pin,
   input wire logic serial_out_pin,
   // data side
   input wire logic clock_to_source,
   input wire logic [DATA_WIDTH-1:0] dac_i_word,
   input wire logic [DATA_WIDTH-1:0] dac_q_word,
   input wire logic dac_word_valid,
   input wire logic dac_ready,
   // control words
   input wire logic [7:0] data_control,
   input wire logic [7:0] power_down,
   input wire logic [7:0] mix_mode,
   input wire logic [7:0] aux_one_high,
   input wire logic [7:0] fs_two_high,
   input wire logic [7:0] aux_two_low,
   input wire logic [7:0] aux_two_high
);
   default clocking cb @(posedge clk); endclocking
   // output pair stalled by the sink
   sequence s_stalled;
      dac_word_valid && !dac_ready;
   endsequence
   // clock out enabled and not inverted for three edges
   sequence s_clk_free;
      (!power_down[BIT_PD_CLKOUT] && !data_control[BIT_INV_CLK]) [*3];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_pin_mix_force: assert property (sys_rst && chip_select_pin |=> mix_mode == 8'h05)
      else $error("mix mode not forced in pin mode");
   a_pin_no_mix: assert property (sys_rst && !chip_select_pin |=> mix_mode == 8'h00)
      else $error("mix mode not default in pin mode");
   a_pin_pd_force: assert property (sys_rst && serial_out_pin |=> power_down == 8'hff)
      else $error("power down not forced in pin mode");
   a_pin_format: assert property (sys_rst |=> data_control[7] == $past(serial_data_pin))
      else $error("format bit does not follow data pin");
   a_aux_one_mask: assert property (disable iff (sys_rst)
      reg_wr && reg_addr == 5'h0e |=> aux_one_high == ($past(reg_wdata) & 8'hc3))
      else $error("aux one high byte wrong");
   a_fs_two_high: assert property (disable iff (sys_rst)
      reg_wr && reg_addr == 5'h10 |=> fs_two_high == {6'h00, $past(reg_wdata[1:0])})
      else $error("second full scale high bits wrong");
   a_aux_two_low: assert property (disable iff (sys_rst)
      reg_wr && reg_addr == 5'h11 |=> aux_two_low == $past(reg_wdata))
      else $error("aux two low byte wrong");
   a_aux_two_mask: assert property (disable iff (sys_rst)
      reg_wr && reg_addr == 5'h12 |=> aux_two_high == ($past(reg_wdata) & 8'hc3))
      else $error("aux two high byte wrong");
   a_identity_ro: assert property (disable iff (sys_rst)
      reg_rd && reg_addr == 5'h1f |=> reg_rdata == {SILICON_VERSION, DEVICE_CODE})
      else $error("identity register wrong");
   a_clock_toggle: assert property (disable iff (sys_rst)
      s_clk_free |-> clock_to_source != $past(clock_to_source))
      else $error("clock to source not toggling");
   a_pair_holds: assert property (disable iff (sys_rst)
      s_stalled |=> dac_word_valid && $stable(dac_i_word) && $stable(dac_q_word))
      else $error("stalled pair changed");
endmodule // ddac_front_sva

bind ddac_front ddac_front_sva #(.SILICON_VERSION(SILICON_VERSION), .DEVICE_CODE(DEVICE_CODE),
   .DATA_WIDTH(DATA_WIDTH)) i_ddac_front_sva (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .serial_data_pin, .chip_select_pin, .serial_out_pin, .clock_to_source,
   .dac_i_word, .dac_q_word, .dac_word_valid, .dac_ready, .data_control, .power_down,
   .mix_mode, .aux_one_high, .fs_two_high, .aux_two_low, .aux_two_high);

// *** testbench/ddac_source_model.sv ***
// Purpose: data source sending interleaved pairs on the clock out
// Assumes: I word {1,n}, Q word {2,n}, n counts pairs
// Notes: idle lines invert every step, marking low
`timescale 1ns/100ps
module ddac_source_model (
   // timing from the device
   input wire logic clock_to_source,
   // burst request
   input wire logic src_en,
   // data port
   output logic [15:0] lvds_data,
   output logic iq_marking_clock_in
);
   logic phase_q = 1'b0;
   logic [11:0] pair_n = 12'h000;
   initial lvds_data = 16'h0000;
   initial iq_marking_clock_in = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // one word on each edge of the clock out, marking high for I
   always @(clock_to_source) begin
      #2;
      if (phase_q) begin
         lvds_data = {4'h2, pair_n};
         iq_marking_clock_in = 1'b0;
         pair_n = pair_n + 12'h001;
         phase_q = 1'b0;
      end else if (src_en) begin
         lvds_data = {4'h1, pair_n};
         iq_marking_clock_in = 1'b1;
         phase_q = 1'b1;
      end else begin
         lvds_data = ~lvds_data; // released lines keep moving
         iq_marking_clock_in = 1'b0;
      end
   end
endmodule // ddac_source_model

// *** testbench/test_ddac_front.sv ***
// Purpose: self-checking bench of the converter front end
// Assumes: inputs change at the falling edge, except src_en and dac_ready, which are also set 1 ns after a rising edge
// Notes: pairs are checked at the output handshake
`timescale 1ns/100ps
module test_ddac_front;
   import ddac_pkg::*;
   typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] q;} ddac_row_t;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic serial_data_pin = 1'b1;
   logic chip_select_pin = 1'b1;
   logic serial_out_pin = 1'b1;
   logic src_en = 1'b0;
   logic dac_ready = 1'b1;
   logic [15:0] lvds_data, dac_i_word, dac_q_word;
   logic iq_marking_clock_in, clock_to_source, dac_word_valid;
   logic [7:0] reg_rdata, data_control, power_down, mix_mode, aux_one_low, aux_one_high;
   logic [7:0] fs_two_low, fs_two_high, aux_two_low, aux_two_high, rv, s0;
   logic [11:0] exp_n = 12'h000;
   logic [15:0] sig1 = 16'h0000, sig2 = 16'h0000;
   logic fmt = 1'b1, mon_on = 1'b1, resync = 1'b1, sig_on = 1'b0;
   int fail_count = 0, n_compared = 0, hs_count = 0;
   ddac_row_t rows [10] = '{'{5'h0d, 8'h5a, 8'h5a}, '{5'h0e, 8'hff, 8'hc3},
      '{5'h0f, 8'h00, 8'h00}, '{5'h10, 8'hfe, 8'h02}, '{5'h11, 8'h3c, 8'h3c},
      '{5'h12, 8'h81, 8'h81}, '{5'h04, 8'ha5, 8'ha5}, '{5'h05, 8'hff, 8'h1f},
      '{5'h1f, 8'h00, 8'h12}, '{5'h08, 8'h77, 8'h00}};

   // clock
   always #5 clk = ~clk;

   ddac_front #(.SILICON_VERSION(4'h1), .DEVICE_CODE(4'h2), .DATA_WIDTH(16)) i_ddac_front (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_data_pin(serial_data_pin), .chip_select_pin(chip_select_pin),
      .serial_out_pin(serial_out_pin), .lvds_data(lvds_data),
      .iq_marking_clock_in(iq_marking_clock_in), .clock_to_source(clock_to_source),
      .dac_i_word(dac_i_word), .dac_q_word(dac_q_word), .dac_word_valid(dac_word_valid),
      .dac_ready(dac_ready), .data_control(data_control), .power_down(power_down),
      .mix_mode(mix_mode), .aux_one_low(aux_one_low), .aux_one_high(aux_one_high),
      .fs_two_low(fs_two_low), .fs_two_high(fs_two_high), .aux_two_low(aux_two_low),
      .aux_two_high(aux_two_high));
   ddac_source_model i_ddac_source_model (.clock_to_source(clock_to_source),
      .src_en(src_en), .lvds_data(lvds_data), .iq_marking_clock_in(iq_marking_clock_in));

   ////////////////////////////////////////////////////////////////////////
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      cmp8($sformatf("reg %h", a), exp, d);
   endtask
   task automatic burst(input int n);
      @(negedge clk);
      src_en = 1'b1;
      repeat (2 * n) @(negedge clk);
      src_en = 1'b0;
      repeat (40) @(negedge clk);
   endtask
   function automatic logic [7:0] port_of(input logic [4:0] a);
      case (a)
         5'h0d: return aux_one_low;
         5'h0e: return aux_one_high;
         5'h0f: return fs_two_low;
         5'h10: return fs_two_high;
         5'h11: return aux_two_low;
         default: return aux_two_high;
      endcase
   endfunction
   function automatic logic [15:0] step(input logic [15:0] s, input logic [15:0] w);
      return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]} ^ w;
   endfunction
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // pair monitor at the output handshake
   always @(posedge clk) begin
      if (dac_word_valid === 1'b1 && dac_ready === 1'b1) begin
         hs_count++;
         if (mon_on) begin
            if (resync) exp_n = dac_i_word[11:0];
            resync = 1'b0;
            cmp16("i word", {fmt ? 4'h1 : 4'h9, exp_n}, dac_i_word);
            cmp16("q word", {fmt ? 4'h2 : 4'ha, exp_n}, dac_q_word);
            if (sig_on) {sig1, sig2} = {step(sig1, {4'h1, exp_n}), step(sig2, {4'h2, exp_n})};
            exp_n++;
         end
      end
   end

   // watchdog
   initial begin
      #200000;
      fail_count++;
      results();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #1 cmp8("format", 8'h80, data_control & 8'h80);
      cmp8("mix", 8'h05, mix_mode);
      cmp8("power down", 8'hff, power_down);
      @(negedge clk);
      sys_rst = 1'b0;
      chk(ADDR_FS_TWO_LOW, 8'hf9);
      chk(ADDR_FS_TWO_HIGH, 8'h01);
      chk(ADDR_TEST_CTRL, 8'h00);
      $display("test pin mode and defaults done");
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         chk(rows[k].a, rows[k].q);
         if (rows[k].a >= 5'h0d && rows[k].a <= 5'h12)
            cmp8("port", rows[k].q, port_of(rows[k].a));
      end
      wr(ADDR_SETUP_HOLD, 8'h00);
      wr(ADDR_SAMPLE_DLY, 8'h00);
      wr(ADDR_POWER_DOWN, 8'h00);
      $display("test register table done");
      burst(8);
      wr(ADDR_TEST_CTRL, 8'h80);
      {sig1, sig2} = 32'h00000000;
      sig_on = 1'b1;
      burst(6);
      sig_on = 1'b0;
      wr(ADDR_TEST_CTRL, 8'h40);
      for (int k = 0; k < 4; k++)
         chk(ADDR_RES_ONE_LOW + 5'(k), 8'({sig2, sig1} >> (8 * k)));
      wr(ADDR_TEST_CTRL, 8'h20);
      for (int k = 0; k < 4; k++) chk(ADDR_RES_ONE_LOW + 5'(k), 8'h00);
      chk(ADDR_TEST_CTRL, 8'h20);
      $display("test self-test done");
      mon_on = 1'b0;
      src_en = 1'b1;
      repeat (40) @(negedge clk);
      rd(ADDR_SEEK, s0);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_SETUP_HOLD, (k == 0) ? 8'h01 : (k == 1) ? 8'h10 : 8'h11);
         repeat (30) @(negedge clk);
         rd(ADDR_SEEK, rv);
         cmp8("seek", (s0 & 8'h01) ^ {7'h00, k != 2}, rv & 8'h01);
      end
      wr(ADDR_SETUP_HOLD, 8'h00);
      src_en = 1'b0;
      repeat (40) @(negedge clk);
      $display("test sample point done");
      dac_ready = 1'b0;
      burst(FIFO_DEPTH + 8);
      hs_count = 0;
      chk(ADDR_SEEK, 8'h80);
      dac_ready = 1'b1;
      repeat (60) @(negedge clk);
      cmp8("drained", 8'h01, {7'h00, hs_count >= FIFO_DEPTH});
      wr(ADDR_SEEK, 8'h80);
      chk(ADDR_SEEK, 8'h00);
      $display("test buffer full done");
      @(negedge clk);
      sys_rst = 1'b1;
      serial_data_pin = 1'b0;
      chip_select_pin = 1'b0;
      serial_out_pin = 1'b0;
      repeat (12) @(negedge clk);
      cmp8("pin mode off", 8'h00, data_control | mix_mode | power_down);
      sys_rst = 1'b0;
      fmt = 1'b0;
      resync = 1'b1;
      mon_on = 1'b1;
      burst(8);
      $display("test twos complement done");
      results();
   end
endmodule // test_ddac_front
